// file: core/bit_op_instruction_exec.sv
// Execute stage for bit clear, bit set, skip-if-bit-set and AND-literal.
// Assumes the file register array presents the data of instr[4:0] on
// file_rdata in the same cycle, and applies file writes one cycle later.
// Assumes acc_load with acc_load_data, on the same clock, carries any
// accumulator write made by a word outside this group.
// Words outside the group are no-operations here apart from that write.
//
// How it works
// - Bit clear writes zero to the indexed bit, other bits kept.
// - Bit set writes one to the indexed bit, other bits kept.
// - Skip-if-set tests the indexed bit; set means next instruction has no effect.
// - A taken skip discards the prefetched word and runs a no-operation instead.
// - AND-literal forms accumulator AND the 8-bit immediate.
// - Result goes to the accumulator; zero flag updated, no other flag.
`timescale 1ns/1ps
`default_nettype none
module bit_op_instruction_exec
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [bit_op_pkg::INSTR_W-1:0] instr,
    input wire logic instr_valid,
    input wire logic [bit_op_pkg::DATA_W-1:0] file_rdata,
    // Accumulator write from a word outside this group
    input wire logic acc_load,
    input wire logic [bit_op_pkg::DATA_W-1:0] acc_load_data,
    output logic file_we,
    output logic [bit_op_pkg::ADDR_W-1:0] file_waddr,
    output logic [bit_op_pkg::DATA_W-1:0] file_wdata,
    output logic [bit_op_pkg::DATA_W-1:0] acc,
    output logic zero_flag,
    output logic zero_we,
    output logic skip_discard
);
    import bit_op_pkg::*;

    // ***************************************************************
    // Decode helpers
    // ***************************************************************
    function automatic op_t decode_op(input logic [INSTR_W-1:0] word);
        op_t op;
        op = no_operation;
        case (word[PREFIX_HI:PREFIX_LO])
            PREFIX_BIT_CLEAR: op = bit_clear_op;
            PREFIX_BIT_SET: op = bit_set_op;
            PREFIX_SKIP_IF_SET: op = skip_if_bit_set_op;
            PREFIX_AND_LITERAL: op = and_literal_op;
            default: op = no_operation;
        endcase
        return op;
    endfunction

    // Both file-writing ops take the register address from one field
    function automatic logic [ADDR_W-1:0] file_addr_of(input logic [INSTR_W-1:0] word);
        return word[ADDR_HI:ADDR_LO];
    endfunction

    function automatic logic is_zero(input logic [DATA_W-1:0] value);
        return (value == '0);
    endfunction

    // ***************************************************************
    // State
    // ***************************************************************
    // All registered state in one struct, so every output comes from a flop
    typedef struct packed
    {
        exec_state_t mode;
        logic we;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] acc;
        logic zero;
        logic zero_we;
        logic discard;
    } exec_regs_t;

    exec_regs_t cur;
    exec_regs_t next_cur;

    op_t op;
    logic [BIDX_W-1:0] bidx;
    logic [DATA_W-1:0] literal;
    logic [DATA_W-1:0] and_result;
    logic [DATA_W-1:0] bit_hit;
    logic [DATA_W-1:0] cleared_data;
    logic [DATA_W-1:0] set_data;
    logic tested_bit;

    // ***************************************************************
    // Decoded fields
    // ***************************************************************
    // Decoded for every word; only the case below decides what takes effect
    assign op = decode_op(instr);
    assign bidx = instr[BIDX_HI:BIDX_LO];
    assign literal = instr[LIT_HI:LIT_LO];
    assign and_result = cur.acc & literal;

    // ***************************************************************
    // Bit datapath
    // ***************************************************************
    // One slice per data bit: the indexed bit is forced and the rest pass
    // through, so clear and set share one read-modify-write path
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi = gi + 1)
        begin : g_bit
            assign bit_hit[gi] = (bidx == BIDX_W'(gi));
            assign cleared_data[gi] = bit_hit[gi] ? 1'b0 : file_rdata[gi];
            assign set_data[gi] = bit_hit[gi] ? 1'b1 : file_rdata[gi];
        end
    endgenerate

    assign tested_bit = |(file_rdata & bit_hit);

    // ***************************************************************
    // Next state
    // ***************************************************************
    always_comb
    begin
        next_cur = cur;
        next_cur.we = 1'b0;
        next_cur.zero_we = 1'b0;
        next_cur.discard = 1'b0;
        // A cycle without valid only clears the we, zero_we and discard strobes, so a pending skip waits for a word
        if (instr_valid)
        begin
            case (cur.mode)
                skip_slot:
                begin
                    // Prefetched word squashed; this slot is the skip's second cycle
                    // Limitation: a skip in this slot is dropped too, skips never chain
                    next_cur.mode = run;
                    next_cur.discard = 1'b1;
                end
                run:
                begin
                    case (op)
                        bit_clear_op:
                        begin
                            next_cur.we = 1'b1;
                            // Array applies it next cycle and forwards it to a back-to-back read
                            next_cur.waddr = file_addr_of(instr);
                            next_cur.wdata = cleared_data;
                        end
                        bit_set_op:
                        begin
                            next_cur.we = 1'b1;
                            next_cur.waddr = file_addr_of(instr);
                            next_cur.wdata = set_data;
                        end
                        skip_if_bit_set_op:
                        begin
                            if (tested_bit)
                            begin
                                next_cur.mode = skip_slot;
                            end
                        end
                        and_literal_op:
                        begin
                            next_cur.acc = and_result;
                            next_cur.zero = is_zero(and_result);
                            next_cur.zero_we = 1'b1;
                        end
                        no_operation:
                        begin
                            // Word outside this group; only its accumulator write lands here
                            if (acc_load)
                            begin
                                next_cur.acc = acc_load_data;
                            end
                        end
                        default:
                        begin
                            next_cur.mode = run;
                        end
                    endcase
                end
                default:
                begin
                    next_cur.mode = run;
                end
            endcase
        end
    end

    // ***************************************************************
    // Registers
    // ***************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // No skip left pending, so the first word after release executes
            cur.mode <= run;
            cur.we <= 1'b0;
            cur.waddr <= ADDR_RESET;
            cur.wdata <= ACC_RESET;
            cur.acc <= ACC_RESET;
            cur.zero <= 1'b0;
            cur.zero_we <= 1'b0;
            cur.discard <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    // Every output is a register field; nothing combinational reaches a pin
    assign file_we = cur.we;
    assign file_waddr = cur.waddr;
    assign file_wdata = cur.wdata;
    assign acc = cur.acc;
    assign zero_flag = cur.zero;
    assign zero_we = cur.zero_we;
    assign skip_discard = cur.discard;
endmodule
`default_nettype wire

// file: core/bit_op_pkg.sv
// Constants for the bit-operation and AND-literal execute block.
// Assumes a 12-bit instruction word and 8-bit file registers.
package bit_op_pkg;
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int BIDX_W = 3;
    localparam int PREFIX_HI = 11;
    localparam int PREFIX_LO = 8;
    localparam int BIDX_HI = 7;
    localparam int BIDX_LO = 5;
    localparam int ADDR_HI = 4;
    localparam int ADDR_LO = 0;
    localparam int LIT_HI = 7;
    localparam int LIT_LO = 0;
    localparam logic [3:0] PREFIX_BIT_CLEAR = 4'h4;
    localparam logic [3:0] PREFIX_BIT_SET = 4'h5;
    localparam logic [3:0] PREFIX_SKIP_IF_SET = 4'h7;
    localparam logic [3:0] PREFIX_AND_LITERAL = 4'hE;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;

    typedef enum logic [2:0]
    {
        no_operation = 3'b000,
        bit_clear_op = 3'b001,
        bit_set_op = 3'b010,
        skip_if_bit_set_op = 3'b011,
        and_literal_op = 3'b100
    } op_t;

    typedef enum logic [0:0]
    {
        run = 1'b0,
        skip_slot = 1'b1
    } exec_state_t;
endpackage

// file: dv/bit_op_properties.sv
// Port checker for the bit-op execute block.
// Assumes a bind onto bit_op_instruction_exec.
`timescale 1ns/1ps
`default_nettype none
module bit_op_properties
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] instr,
    input wire logic instr_valid,
    input wire logic [7:0] file_rdata,
    input wire logic file_we,
    input wire logic [4:0] file_waddr,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] acc,
    input wire logic zero_flag,
    input wire logic zero_we,
    input wire logic skip_discard
);
    logic skp;
    logic go;
    logic [3:0] op;
    assign op = instr[11:8];
    assign go = instr_valid && !skp;
    // Slot after a taken skip, so discarded words are not judged as executed
    always_ff @(posedge clk or posedge rst)
        if (rst) skp <= 1'b0;
        else if (instr_valid) skp <= go && op == 4'h7 && file_rdata[instr[7:5]];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    clear_bit_a: assert property (go && op == 4'h4 |=> file_we &&
        file_wdata == ($past(file_rdata) & ~(8'h01 << $past(instr[7:5])))) else $error("bad clear");
    set_bit_a: assert property (go && op == 4'h5 |=> file_we && file_waddr == $past(instr[4:0]) &&
        file_wdata == ($past(file_rdata) | (8'h01 << $past(instr[7:5])))) else $error("bad set");
    skip_drop_a: assert property (instr_valid && skp |=>
        skip_discard && !file_we && !zero_we && $stable(acc)) else $error("slot not dropped");
    skip_cause_a: assert property (skip_discard |-> $past(skp) && $past(instr_valid)) else $error("stray skip");
    and_acc_a: assert property (go && op == 4'hE |=>
        zero_we && acc == ($past(acc) & $past(instr[7:0]))) else $error("bad and");
    zero_val_a: assert property (zero_we |-> zero_flag == (acc == 8'h00)) else $error("bad zero");
    zero_src_a: assert property (!(go && op == 4'hE) |=> !zero_we && $stable(zero_flag)) else $error("zero moved");
    bit_quiet_a: assert property (go && op inside {4'h4, 4'h5} |=> !zero_we && $stable(acc)) else $error("acc moved");
endmodule
bind bit_op_instruction_exec bit_op_properties i_props (.*);
`default_nettype wire

// file: dv/file_regs_model.sv
// File register array facing the execute block.
// Assumes file writes land one edge after file_we.
`timescale 1ns/1ps
`default_nettype none
module file_regs_model
(
    input wire logic clk,
    input wire logic [4:0] raddr,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [32];
    initial
    begin
        for (int i = 0; i < 32; i++) mem[i] = 8'(i * 37);
    end
    // Forward the pending write, else back-to-back ops read stale data
    assign rdata = (we && waddr == raddr) ? wdata : mem[raddr];
    always @(posedge clk)
    begin
        if (we) mem[waddr] <= wdata;
    end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Random instruction stream against a reference model.
// Assumes file_regs_model starts with the same contents.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst = 1, instr_valid = 0, acc_load = 0, file_we, zero_flag, zero_we, skip_discard;
    logic [11:0] instr = 12'h000;
    logic [7:0] file_rdata, file_wdata, acc, acc_load_data = 8'h00;
    logic [4:0] file_waddr;
    int err_count = 0, checks_done = 0, seed = 27, cyc = 0, mem [32];
    int m_acc = 0, m_z = 0, m_skp = 0, e_we = 0, e_zwe = 0, e_sd = 0, e_wa = 0, e_wd = 0, v, a, b;
    bit_op_instruction_exec i_dut (.clk(clk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
        .file_rdata(file_rdata), .acc_load(acc_load), .acc_load_data(acc_load_data),
        .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
        .acc(acc), .zero_flag(zero_flag), .zero_we(zero_we), .skip_discard(skip_discard));
    file_regs_model i_regs (.clk(clk), .raddr(instr[4:0]), .we(file_we), .waddr(file_waddr),
        .wdata(file_wdata), .rdata(file_rdata));
    task automatic check(string name, logic [7:0] seen, int exp);
        checks_done++;
        if (seen !== 8'(exp))
        begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial forever #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        if (++cyc > 5000)
        begin
            err_count++;
            test_done();
        end
    end
    initial
    begin
        for (int i = 0; i < 32; i++) mem[i] = (i * 37) & 255;
        repeat (8) @(negedge clk);
        rst = 0;
        for (int n = 0; n < 2000; n++)
        begin
            @(negedge clk);
            check("file_we", file_we, e_we);
            if (e_we) check("file_waddr", file_waddr, e_wa);
            if (e_we) check("file_wdata", file_wdata, e_wd);
            check("acc", acc, m_acc);
            check("zero_flag", zero_flag, m_z);
            check("zero_we", zero_we, e_zwe);
            check("skip_discard", skip_discard, e_sd);
            if (n == 1000)
            begin
                // Idle one cycle so the pending write lands, then reset in mid-run
                instr_valid = 0;
                @(negedge clk);
                rst = 1;
                repeat (2) @(negedge clk);
                rst = 0;
                m_acc = 0;
                m_z = 0;
                m_skp = 0;
                e_we = 0;
                e_zwe = 0;
                e_sd = 0;
                continue;
            end
            v = $random(seed);
            instr = {v[15] & v[14] ? v[11:8] : 4'(16'hE754 >> 4 * v[13:12]), v[7:0]};
            instr_valid = v[16] | v[17];
            acc_load = v[18];
            acc_load_data = v[26:19];
            e_we = 0;
            e_zwe = 0;
            e_sd = 0;
            a = instr[4:0];
            b = 1 << instr[7:5];
            if (instr_valid && m_skp)
            begin
                m_skp = 0;
                e_sd = 1;
            end
            else if (instr_valid)
            begin
                case (instr[11:8])
                    4'h4, 4'h5:
                    begin
                        e_we = 1;
                        e_wa = a;
                        e_wd = instr[8] ? mem[a] | b : mem[a] & ~b;
                        mem[a] = e_wd;
                    end
                    4'h7: m_skp = (mem[a] & b) != 0;
                    4'hE:
                    begin
                        m_acc &= instr[7:0];
                        m_z = m_acc == 0;
                        e_zwe = 1;
                    end
                    default:
                    begin
                        if (acc_load) m_acc = acc_load_data;
                    end
                endcase
            end
        end
        test_done();
    end
endmodule
`default_nettype wire
